// *** hw/ejmc_pkg.sv ***
/*
  Constants for the ejector mode controller: register map, field
  positions, reset values, modes and timing counts.
  Assumes a 50 MHz system clock.
*/
package ejmc_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned HOLD_MS = 3000;
  localparam int unsigned FLASH_MS = 500;
  localparam int unsigned PROT_WIN_MS = 3000;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_CYC = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned PROT_CYC = PROT_WIN_MS * (CLK_HZ / 1000);
  localparam logic [3:0] PROT_MAX_SW = 4'h6;
  localparam logic [7:0] OFS_OUT_PROC = 8'h00;
  localparam logic [7:0] OFS_IN_PROC = 8'h04;
  localparam logic [7:0] OFS_VAC_LIM = 8'h08;
  localparam logic [7:0] OFS_PART_LIM = 8'h0C;
  localparam logic [7:0] OFS_PRES_LIM = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_IDENT = 8'h1C;
  localparam logic [7:0] OFS_TEXT0 = 8'h20;
  localparam int TEXT_WORDS = 4;
  localparam int OPB_SUCTION = 0;
  localparam int OPB_BLOW = 1;
  localparam int OPB_SETUP = 2;
  localparam int CFG_IMPULSE = 2;
  localparam int STS_CM = 4;
  localparam logic [31:0] VAC_LIM_RST = 32'h0096_02EE;
  localparam logic [31:0] PART_LIM_RST = 32'h000A_0226;
  localparam logic [31:0] PRES_LIM_RST = 32'h0032_0FA0;
  localparam logic [2:0] CFG_RST = 3'h1;
  localparam logic [15:0] PART_DEP_MBAR = 16'h0014;
  localparam logic [15:0] UV_MILLIVOLT = 16'h4B00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_AUTO = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_SETUP = 2'b10
  } ejmc_mode_t;
endpackage

// *** hw/ejmc_top.sv ***
/*
  Ejector mode controller: automatic, manual and setup modes, suction
  regulation, part-deposited detection, undervoltage flag, valve drive,
  process data and settings behind an AXI4-Lite slave.
  Assumes all inputs synchronous to CLK and readings in mbar and mV.
*/
// Notes on behaviour
// - After reset the controller runs in automatic mode.
// - Both keys held three seconds enter manual mode; threshold LEDs flash.
// - Exit key or any external command change returns to automatic mode.
// - Manual suction key toggles suction; blow-off key also stops it.
// - Manual blow-off valve and LED follow the held blow-off key.
// - Switching-frequency protection is off in manual mode.
// - With control selected, regulation also acts on manual suction.
// - Output process bit 2 enters or leaves setup, only in IO-Link mode.
// - A change of process bit 0 or 1 ends setup mode.
// - Setup mode disables protection, keeps regulation, flashes both LEDs.
// - Supply below undervoltage threshold raises an error flag.
// - After part-present, vacuum below 20 mbar sets part-deposited.
// - A new suction-on command clears part-deposited.
// - Impulse variant starts off and sucks only after a suction pulse.
// - Input process data reports thresholds, indicators, CM and error.
// - Vacuum control limit and hysteresis are the regulation thresholds.
// - Settings are readable and writable; identity and user text exist.
// - Regulation stops at the limit, resumes below limit minus hysteresis.
module ejmc_top #(
  parameter int unsigned HOLD_CYCLES = ejmc_pkg::HOLD_CYC,
  parameter int unsigned FLASH_CYCLES = ejmc_pkg::FLASH_CYC,
  parameter int unsigned PROT_CYCLES = ejmc_pkg::PROT_CYC,
  // Arbitrary identity value
  parameter logic [31:0] IDENT_CODE = 32'h0000_0001
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic IOLINK_MODE,
  input wire logic SUCTION_IN,
  input wire logic BLOWOFF_IN,
  input wire logic KEY_UP,
  input wire logic KEY_DOWN,
  input wire logic KEY_EXIT,
  input wire logic KEY_SUCTION,
  input wire logic KEY_BLOWOFF,
  input wire logic [15:0] VACUUM_MBAR,
  input wire logic [15:0] PRESSURE_MBAR,
  input wire logic [15:0] SUPPLY_MV,
  output logic VALVE_SUCTION,
  output logic VALVE_BLOWOFF,
  output logic LED_SUCTION,
  output logic LED_BLOWOFF,
  output logic LED_H1,
  output logic LED_H2,
  output logic UNDERVOLT
);
  import ejmc_pkg::*;

  ejmc_mode_t mode_r, mode_nxt;
  logic [2:0] opd_r, opd_nxt, cfg_r, cfg_nxt, thr_r, thr_nxt;
  logic [31:0] vac_lim_r, vac_lim_nxt, part_lim_r, part_lim_nxt, pres_lim_r, pres_lim_nxt;
  logic [31:0] text_r [TEXT_WORDS];
  logic [31:0] text_nxt [TEXT_WORDS];
  logic [31:0] hold_r, hold_nxt, flash_cnt_r, flash_cnt_nxt, win_r, win_nxt;
  logic [3:0] sw_r, sw_nxt;
  logic [1:0] cmd_q_r, cmd_q_nxt;
  logic flash_r, flash_nxt, man_suck_r, man_suck_nxt, setup_q_r, setup_q_nxt;
  logic imp_r, imp_nxt, asuck_q_r, asuck_q_nxt, seen_r, seen_nxt, dep_r, dep_nxt;
  logic trip_r, trip_nxt, cm_r, cm_nxt, uv_r, uv_nxt, vs_q_r;
  logic vs_r, vs_nxt, vb_r, vb_nxt, ks_q_r, ks_q_nxt, kb_q_r, kb_q_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic cmd_suck, cmd_blow, auto_suck, ext_chg, suck_rise, regulating, low_vac;
  logic [15:0] meas [3];
  logic [31:0] lims [3];
  logic [8:0] in_proc;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction

  assign cmd_suck = IOLINK_MODE ? opd_r[OPB_SUCTION] : SUCTION_IN;
  assign cmd_blow = IOLINK_MODE ? opd_r[OPB_BLOW] : BLOWOFF_IN;
  assign ext_chg = {cmd_blow, cmd_suck} != cmd_q_r;
  assign auto_suck = cfg_r[CFG_IMPULSE] ? imp_r : cmd_suck;
  assign suck_rise = auto_suck & ~asuck_q_r;
  // protection only trips in automatic mode
  assign regulating = (cfg_r[1:0] != 2'h0) && !(trip_r && mode_r == MODE_AUTO);
  assign low_vac = VACUUM_MBAR < PART_DEP_MBAR;
  assign meas[0] = VACUUM_MBAR;
  assign meas[1] = VACUUM_MBAR;
  assign meas[2] = PRESSURE_MBAR;
  assign lims[0] = vac_lim_r;
  assign lims[1] = part_lim_r;
  assign lims[2] = pres_lim_r;

  for (genvar i = 0; i < 3; i++) begin : g_thr
    always_comb begin
      if (meas[i] >= lims[i][15:0]) thr_nxt[i] = 1'b1;
      else if ({1'b0, meas[i]} + {1'b0, lims[i][31:16]} < {1'b0, lims[i][15:0]})
        thr_nxt[i] = 1'b0;
      else thr_nxt[i] = thr_r[i];
    end
  end

  assign in_proc = {uv_r, cm_r, mode_r != MODE_AUTO, uv_r, !uv_r && !cm_r, dep_r, thr_r};

  always_comb begin
    mode_nxt = mode_r;
    hold_nxt = 32'h0000_0000;
    man_suck_nxt = man_suck_r;
    flash_cnt_nxt = flash_cnt_r + 32'h0000_0001;
    flash_nxt = flash_r;
    if (flash_cnt_r >= FLASH_CYCLES - 1) begin
      flash_cnt_nxt = 32'h0000_0000;
      flash_nxt = !flash_r;
    end
    case (mode_r)
      MODE_AUTO: begin
        if (KEY_UP && KEY_DOWN) hold_nxt = hold_r + 32'h0000_0001;
        if (hold_r >= HOLD_CYCLES - 1) mode_nxt = MODE_MANUAL;
        // setup entered on a rising bit 2
        else if (IOLINK_MODE && opd_r[OPB_SETUP] && !setup_q_r) mode_nxt = MODE_SETUP;
        man_suck_nxt = 1'b0;
      end
      MODE_MANUAL: begin
        if (KEY_BLOWOFF && !kb_q_r) man_suck_nxt = 1'b0;
        else if (KEY_SUCTION && !ks_q_r) man_suck_nxt = !man_suck_r;
        if (KEY_EXIT || ext_chg) mode_nxt = MODE_AUTO;
      end
      MODE_SETUP: begin
        if (!IOLINK_MODE || !opd_r[OPB_SETUP] || ext_chg) mode_nxt = MODE_AUTO;
      end
      default: mode_nxt = MODE_AUTO;
    endcase
    imp_nxt = imp_r;
    if (cmd_suck && !cmd_q_r[0]) imp_nxt = 1'b1;
    else if (cmd_blow && !cmd_q_r[1]) imp_nxt = 1'b0;
    seen_nxt = suck_rise ? 1'b0 : (seen_r | thr_r[1]);
    dep_nxt = (seen_r && low_vac) ? 1'b1 : (suck_rise ? 1'b0 : dep_r);
    uv_nxt = SUPPLY_MV < UV_MILLIVOLT;
    vb_nxt = (mode_r == MODE_MANUAL) ? KEY_BLOWOFF : cmd_blow;
    vs_nxt = ((mode_r == MODE_MANUAL) ? man_suck_r : auto_suck) && !vb_nxt &&
             (!regulating || !thr_r[0]);
    // Counts valve turn-ons per window; too many means leakage cycling
    win_nxt = win_r + 32'h0000_0001;
    sw_nxt = sw_r + {3'h0, vs_r && !vs_q_r};
    trip_nxt = suck_rise ? 1'b0 : trip_r;
    cm_nxt = cm_r;
    if (win_r >= PROT_CYCLES - 1) begin
      win_nxt = 32'h0000_0000;
      sw_nxt = 4'h0;
    end
    if (mode_r == MODE_AUTO && cfg_r[1:0] != 2'h0 && sw_r > PROT_MAX_SW) begin
      trip_nxt = 1'b1;
      sw_nxt = 4'h0;
    end
    cmd_q_nxt = {cmd_blow, cmd_suck};
    setup_q_nxt = opd_r[OPB_SETUP];
    asuck_q_nxt = auto_suck;
    ks_q_nxt = KEY_SUCTION;
    kb_q_nxt = KEY_BLOWOFF;
    // Register bus, write then read
    aw_ok_nxt = aw_ok_r;
    aw_addr_nxt = aw_addr_r;
    w_ok_nxt = w_ok_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bv_nxt = bv_r && !S_AXI_BREADY;
    bresp_nxt = bresp_r;
    opd_nxt = opd_r;
    cfg_nxt = cfg_r;
    vac_lim_nxt = vac_lim_r;
    part_lim_nxt = part_lim_r;
    pres_lim_nxt = pres_lim_r;
    text_nxt = text_r;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_ok_nxt = 1'b1;
      aw_addr_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_ok_nxt = 1'b1;
      w_data_nxt = S_AXI_WDATA;
      w_strb_nxt = S_AXI_WSTRB;
    end
    if (aw_ok_r && w_ok_r && !bv_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case (aw_addr_r)
        OFS_OUT_PROC: if (w_strb_r[0]) opd_nxt = w_data_r[2:0];
        OFS_VAC_LIM: vac_lim_nxt = merge(vac_lim_r, w_data_r, w_strb_r);
        OFS_PART_LIM: part_lim_nxt = merge(part_lim_r, w_data_r, w_strb_r);
        OFS_PRES_LIM: pres_lim_nxt = merge(pres_lim_r, w_data_r, w_strb_r);
        OFS_CONFIG: if (w_strb_r[0]) cfg_nxt = w_data_r[2:0];
        OFS_STATUS: if (w_strb_r[0] && w_data_r[STS_CM]) cm_nxt = 1'b0;
        OFS_IN_PROC, OFS_IDENT: bresp_nxt = RESP_OKAY;
        default: begin
          if (aw_addr_r[7:4] == OFS_TEXT0[7:4] && aw_addr_r[1:0] == 2'h0)
            text_nxt[aw_addr_r[3:2]] = merge(text_r[aw_addr_r[3:2]], w_data_r, w_strb_r);
          else bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    // Protection event is sticky and beats a software clear
    if (trip_nxt && !trip_r) cm_nxt = 1'b1;
    rv_nxt = rv_r && !S_AXI_RREADY;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (S_AXI_ARADDR)
        OFS_OUT_PROC: rdata_nxt[2:0] = opd_r;
        OFS_IN_PROC: rdata_nxt[8:0] = in_proc;
        OFS_VAC_LIM: rdata_nxt = vac_lim_r;
        OFS_PART_LIM: rdata_nxt = part_lim_r;
        OFS_PRES_LIM: rdata_nxt = pres_lim_r;
        OFS_CONFIG: rdata_nxt[2:0] = cfg_r;
        OFS_STATUS: rdata_nxt[4:0] = {cm_r, trip_r, uv_r, mode_r};
        OFS_IDENT: rdata_nxt = IDENT_CODE;
        default: begin
          if (S_AXI_ARADDR[7:4] == OFS_TEXT0[7:4] && S_AXI_ARADDR[1:0] == 2'h0)
            rdata_nxt = text_r[S_AXI_ARADDR[3:2]];
          else rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      mode_r <= MODE_AUTO;
      {opd_r, thr_r, cmd_q_r, sw_r, w_strb_r, bresp_r, rresp_r} <= '0;
      cfg_r <= CFG_RST;
      vac_lim_r <= VAC_LIM_RST;
      part_lim_r <= PART_LIM_RST;
      pres_lim_r <= PRES_LIM_RST;
      for (int k = 0; k < TEXT_WORDS; k++) text_r[k] <= 32'h0000_0000;
      {hold_r, flash_cnt_r, win_r, w_data_r, rdata_r, aw_addr_r} <= '0;
      {flash_r, man_suck_r, setup_q_r, imp_r, asuck_q_r, seen_r, dep_r} <= '0;
      {trip_r, cm_r, uv_r, vs_r, vb_r, ks_q_r, kb_q_r, vs_q_r} <= '0;
      {aw_ok_r, w_ok_r, bv_r, rv_r} <= '0;
    end else begin
      mode_r <= mode_nxt;
      {opd_r, thr_r, cmd_q_r, sw_r, w_strb_r, bresp_r, rresp_r} <=
        {opd_nxt, thr_nxt, cmd_q_nxt, sw_nxt, w_strb_nxt, bresp_nxt, rresp_nxt};
      cfg_r <= cfg_nxt;
      vac_lim_r <= vac_lim_nxt;
      part_lim_r <= part_lim_nxt;
      pres_lim_r <= pres_lim_nxt;
      text_r <= text_nxt;
      {hold_r, flash_cnt_r, win_r, w_data_r, rdata_r, aw_addr_r} <=
        {hold_nxt, flash_cnt_nxt, win_nxt, w_data_nxt, rdata_nxt, aw_addr_nxt};
      {flash_r, man_suck_r, setup_q_r, imp_r, asuck_q_r, seen_r, dep_r} <=
        {flash_nxt, man_suck_nxt, setup_q_nxt, imp_nxt, asuck_q_nxt, seen_nxt, dep_nxt};
      {trip_r, cm_r, uv_r, vs_r, vb_r, ks_q_r, kb_q_r, vs_q_r} <=
        {trip_nxt, cm_nxt, uv_nxt, vs_nxt, vb_nxt, ks_q_nxt, kb_q_nxt, vs_r};
      {aw_ok_r, w_ok_r, bv_r, rv_r} <= {aw_ok_nxt, w_ok_nxt, bv_nxt, rv_nxt};
    end
  end

  assign S_AXI_AWREADY = !aw_ok_r && !bv_r;
  assign S_AXI_WREADY = !w_ok_r && !bv_r;
  assign S_AXI_BVALID = bv_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = !rv_r;
  assign S_AXI_RVALID = rv_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign VALVE_SUCTION = vs_r;
  assign VALVE_BLOWOFF = vb_r;
  assign LED_SUCTION = vs_r;
  assign LED_BLOWOFF = vb_r;
  assign LED_H1 = (mode_r != MODE_AUTO) ? flash_r : thr_r[0];
  assign LED_H2 = (mode_r != MODE_AUTO) ? flash_r : thr_r[1];
  assign UNDERVOLT = uv_r;

  chk_power_up_auto: assert property (@(posedge CLK) disable iff (RESET)
    $past(RESET) |-> mode_r == MODE_AUTO) else $error("not automatic after reset");
  chk_manual_leds: assert property (@(posedge CLK) disable iff (RESET)
    mode_r == MODE_MANUAL |-> LED_H1 == LED_H2) else $error("manual LEDs differ");
  chk_manual_exit: assert property (@(posedge CLK) disable iff (RESET)
    mode_r == MODE_MANUAL && KEY_EXIT |=> mode_r == MODE_AUTO) else $error("no manual exit");
  chk_blow_stops_suck: assert property (@(posedge CLK) disable iff (RESET)
    mode_r == MODE_MANUAL && KEY_BLOWOFF && !kb_q_r |=> !man_suck_r)
    else $error("suction not stopped");
  chk_manual_blow: assert property (@(posedge CLK) disable iff (RESET)
    mode_r == MODE_MANUAL ##1 1'b1 |-> VALVE_BLOWOFF == $past(KEY_BLOWOFF))
    else $error("blow-off not following key");
  chk_setup_exit: assert property (@(posedge CLK) disable iff (RESET)
    mode_r == MODE_SETUP && ext_chg |=> mode_r == MODE_AUTO) else $error("setup kept");
  chk_undervolt: assert property (@(posedge CLK) disable iff (RESET)
    SUPPLY_MV < UV_MILLIVOLT |=> UNDERVOLT) else $error("undervoltage missed");
  chk_part_dep: assert property (@(posedge CLK) disable iff (RESET)
    seen_r && low_vac |=> dep_r) else $error("part deposited missed");
  chk_dep_clear: assert property (@(posedge CLK) disable iff (RESET)
    suck_rise && !(seen_r && low_vac) |=> !dep_r) else $error("deposit not cleared");
  chk_reg_stop: assert property (@(posedge CLK) disable iff (RESET)
    regulating && thr_r[0] |=> !VALVE_SUCTION) else $error("suction past limit");
endmodule

// *** tb/ejmc_host.sv ***
/*
  AXI4-Lite master standing in for the process controller.
  Assumes its tasks are called right after a rising clk edge.
*/
module ejmc_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Process commands as writes
  // Sampled at the falling edge: readies only move after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (ta) awaddr <= ~a;
      if (tw) wvalid <= 1'b0;
      if (tw) wdata <= ~d;
      n++;
    end while (!tb && n < 200);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (ta) araddr <= ~a;
      n++;
    end while (!tr && n < 200);
    rready <= 1'b0;
  endtask
endmodule

// *** tb/ejector_mode_controller_test.sv ***
/*
  Self-checking bench for the ejector mode controller.
  Assumes shortened hold, flash and protection counts.
*/
module ejector_mode_controller_test;
  import ejmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [31:0] ID_VAL = 32'h0000_5A3C;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst, iol, suc, blo, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, vs, vb, ls, lb, lh1, lh2, uv;
  logic [4:0] keys;
  logic [15:0] vac, prs, sup;
  logic [7:0] awaddr, araddr, a;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [34:0] exp_q [$];
  logic [34:0] msk_q [$];
  logic [2:0] pd [7] = '{3'h4, 3'h5, 3'h4, 3'h0, 3'h2, 3'h6, 3'h4};
  logic [1:0] md [7] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
  int err_total = 0;
  int checked = 0;
  always #10 clk = ~clk;
  ejmc_top #(.HOLD_CYCLES(HOLD), .FLASH_CYCLES(4), .PROT_CYCLES(50), .IDENT_CODE(ID_VAL)) dut (
    .CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IOLINK_MODE(iol), .SUCTION_IN(suc), .BLOWOFF_IN(blo), .KEY_UP(keys[0]),
    .KEY_DOWN(keys[1]), .KEY_EXIT(keys[2]), .KEY_SUCTION(keys[3]), .KEY_BLOWOFF(keys[4]),
    .VACUUM_MBAR(vac), .PRESSURE_MBAR(prs), .SUPPLY_MV(sup), .VALVE_SUCTION(vs),
    .VALVE_BLOWOFF(vb), .LED_SUCTION(ls), .LED_BLOWOFF(lb), .LED_H1(lh1), .LED_H2(lh2),
    .UNDERVOLT(uv));
  ejmc_host u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));
  task automatic print_verdict();
    // A transfer that never answered leaves its note behind
    if (exp_q.size() != 0) err_total++;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic miss(input logic [34:0] g, input logic [34:0] e);
    err_total++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic cmp(input logic [34:0] g);
    logic [34:0] e, m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    checked++;
    if ((g & m) !== e) miss(g & m, e);
  endtask
  // Responses are settled at the falling edge before their handshake
  always @(negedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) cmp({1'b0, rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) cmp({1'b1, bresp, 32'h0000_0000});
  end
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({1'b1, r, 32'h0000_0000});
    msk_q.push_back('1);
    u_host.wr(ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    exp_q.push_back({1'b0, r, e});
    msk_q.push_back({3'h7, m});
    u_host.rd(ad);
  endtask
  task automatic pin(input logic g, input logic e);
    @(negedge clk);
    checked++;
    if (g !== e) miss({34'h0, g}, {34'h0, e});
    @(posedge clk);
  endtask
  task automatic setv(input logic [15:0] x, input logic e);
    vac <= x;
    cy(4);
    pin(vs, e);
  endtask
  task automatic press(input int k);
    keys[k] <= 1'b1;
    cy(2);
    keys[k] <= 1'b0;
    cy(4);
  endtask
  task automatic hold(input int n);
    keys <= 5'h03;
    cy(n);
    keys <= 5'h00;
    cy(3);
  endtask
  task automatic flash_chk();
    int t;
    logic p;
    t = 0;
    p = lh1;
    repeat (16) begin
      @(negedge clk);
      checked++;
      if (lh1 !== lh2) miss({34'h0, lh1}, {34'h0, lh2});
      if (lh1 !== p) t++;
      p = lh1;
    end
    @(posedge clk);
    pin(t >= 2, 1'b1);
  endtask
  initial begin
    #400_000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(43));
    rst = 1'b1;
    keys = 5'h00;
    iol = 1'b0;
    suc = 1'b0;
    blo = 1'b0;
    vac = 16'h0064;
    prs = 16'h0000;
    sup = 16'h6000;
    cy(4);
    rst <= 1'b0;
    cy(1);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    rd(OFS_VAC_LIM, VAC_LIM_RST, '1, RESP_OKAY);
    rd(OFS_PART_LIM, PART_LIM_RST, '1, RESP_OKAY);
    rd(OFS_PRES_LIM, PRES_LIM_RST, '1, RESP_OKAY);
    rd(OFS_IDENT, ID_VAL, '1, RESP_OKAY);
    rd(8'h40, 32'h0000_0000, '1, RESP_SLVERR);
    wr(8'h44, 32'h0000_FFFF, RESP_SLVERR);
    wr(OFS_IN_PROC, '1, RESP_OKAY);
    rd(OFS_IN_PROC, 32'h0000_0000, 32'h0000_0128, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? OFS_VAC_LIM : 8'(OFS_TEXT0 + 4 * (i - 1));
      v = $urandom;
      wr(a, v, RESP_OKAY);
      rd(a, v, '1, RESP_OKAY);
    end
    wr(OFS_VAC_LIM, VAC_LIM_RST, RESP_OKAY);
    suc <= 1'b1;
    cy(4);
    pin(vs, 1'b1);
    setv(16'h02EE, 1'b0);
    setv(16'h028A, 1'b0);
    setv(16'h0257, 1'b1);
    setv(16'h0258, 1'b1);
    setv(16'h0014, 1'b1);
    rd(OFS_IN_PROC, 32'h0000_0000, 32'h0000_0008, RESP_OKAY);
    setv(16'h0013, 1'b1);
    rd(OFS_IN_PROC, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
    // Vacuum back above 20 mbar, else the deposit flag sets again at once
    vac <= 16'h0064;
    suc <= 1'b0;
    cy(3);
    suc <= 1'b1;
    cy(4);
    rd(OFS_IN_PROC, 32'h0000_0000, 32'h0000_0008, RESP_OKAY);
    sup <= 16'($urandom_range(19199, 18000));
    cy(3);
    pin(uv, 1'b1);
    rd(OFS_IN_PROC, 32'h0000_0120, 32'h0000_0120, RESP_OKAY);
    sup <= 16'h4B00;
    cy(3);
    pin(uv, 1'b0);
    vac <= 16'h0064;
    hold(HOLD - 10);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    hold(HOLD + 4);
    rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0003, RESP_OKAY);
    flash_chk();
    pin(vs, 1'b0);
    press(3);
    pin(ls, 1'b1);
    setv(16'h0320, 1'b0);
    setv(16'h0064, 1'b1);
    press(3);
    pin(vs, 1'b0);
    press(3);
    keys[4] <= 1'b1;
    cy(4);
    pin(vb, 1'b1);
    pin(lb, 1'b1);
    pin(vs, 1'b0);
    keys[4] <= 1'b0;
    cy(4);
    pin(vb, 1'b0);
    press(2);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    pin(vs, 1'b1);
    hold(HOLD + 4);
    blo <= 1'b1;
    cy(4);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    pin(vb, 1'b1);
    blo <= 1'b0;
    iol <= 1'b1;
    cy(2);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_OUT_PROC, 32'(pd[i]), RESP_OKAY);
      cy(2);
      rd(OFS_STATUS, 32'(md[i]), 32'h0000_0003, RESP_OKAY);
      rd(OFS_IN_PROC, (md[i] == 2'h2) ? 32'h0000_0040 : 32'h0, 32'h0000_0040, RESP_OKAY);
      if (i == 0) flash_chk();
    end
    wr(OFS_OUT_PROC, 32'h0000_0000, RESP_OKAY);
    iol <= 1'b0;
    wr(OFS_OUT_PROC, 32'h0000_0004, RESP_OKAY);
    cy(2);
    rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003, RESP_OKAY);
    cy(4);
    print_verdict();
  end
endmodule
